// ===== src/cfia_pkg.sv
// package for the can fd interrupt aggregation block
package cfia_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [5:0] CFIA_OFS_ENABLE       = 6'h00;
	localparam logic [5:0] CFIA_OFS_FLAGS        = 6'h04;
	localparam logic [5:0] CFIA_OFS_RX_PEND_HI   = 6'h08;
	localparam logic [5:0] CFIA_OFS_RX_PEND_LO   = 6'h0c;
	localparam logic [5:0] CFIA_OFS_RX_OVF_HI    = 6'h10;
	localparam logic [5:0] CFIA_OFS_RX_OVF_LO    = 6'h14;
	localparam logic [5:0] CFIA_OFS_TX_PEND_HI   = 6'h18;
	localparam logic [5:0] CFIA_OFS_TX_PEND_LO   = 6'h1c;
	localparam logic [5:0] CFIA_OFS_TX_ATT_HI    = 6'h20;
	localparam logic [5:0] CFIA_OFS_TX_ATT_LO    = 6'h24;
	localparam logic [5:0] CFIA_OFS_SEND_REQ_HI  = 6'h28;

	// ------------------------------------------------------------
	// field positions, shared by enable and flag registers
	// ------------------------------------------------------------
	localparam int CFIA_BIT_BAD_MSG  = 15;
	localparam int CFIA_BIT_WAKEUP   = 14;
	localparam int CFIA_BIT_BUS_ERR  = 13;
	localparam int CFIA_BIT_SYS_ERR  = 12;
	localparam int CFIA_BIT_RX_OVF   = 11;
	localparam int CFIA_BIT_TX_ATT   = 10;
	localparam int CFIA_BIT_TEF      = 4;
	localparam int CFIA_BIT_MODE     = 3;
	localparam int CFIA_BIT_TBWRAP   = 2;
	localparam int CFIA_BIT_RX_OBJ   = 1;
	localparam int CFIA_BIT_TX_OBJ   = 0;

	// implemented bits of enable and flag registers
	localparam logic [15:0] CFIA_IMPL_MASK  = 16'hfc1f;
	// flags that hardware sets and software clears
	localparam logic [15:0] CFIA_STICKY_MASK = 16'hf00c;
	localparam logic [15:0] CFIA_RESET_VAL  = 16'h0000;
	localparam logic [7:0]  CFIA_RX_FIFO_MASK = 8'hfe;
	localparam int          CFIA_FIFO_COUNT   = 8;

	localparam logic [1:0] CFIA_RESP_OKAY   = 2'b00;
	localparam logic [1:0] CFIA_RESP_SLVERR = 2'b10;

	// per-fifo flag inputs from the fifo status logic
	typedef struct packed {
		logic [7:0] rx_fifo;
		logic [7:0] rx_ovf;
		logic [7:0] tx_fifo;
		logic [7:0] tx_att;
	} cfia_fifo_flags_t;

	// module-level hardware events: one-cycle pulses, except tx_event_fifo, a level that its flag follows
	typedef struct packed {
		logic bad_message;
		logic wakeup;
		logic bus_error;
		logic system_error;
		logic mode_change;
		logic tx_event_fifo;
	} cfia_events_t;

endpackage

// ===== src/cfia_top.sv
// can fd interrupt enables, event flags and per-fifo pending summaries
// Behaviour
// - Enable bits 15..10 cover bad message, wakeup, bus error, system error, rx overflow, tx attempt; 9..5 read 0.
// - Enable bits 4..0 cover tx event fifo, mode change, timebase wrap, rx object and tx object.
// - Bad message, wakeup, bus error, system error, mode change and wrap flags are set by hardware, cleared by software.
// - Rx overflow, tx attempt, tx event fifo, rx object and tx object flags are read-only status; all but tx event fifo reset 0, which follows its input.
// - The timebase wrap flag sets when the free-running timebase wraps and stays until cleared.
// - Each rx pending bit 7..1 is the OR of that fifo's enabled flags, bit 0 reads 0.
// - Each rx overflow pending bit 7..1 follows that fifo's overflow flag, bit 0 reads 0.
// - Each tx pending bit 7..0 is the OR of that fifo's enabled tx flags, bit 0 being the transmit queue.
// - Each tx attempt pending bit 7..0 follows that fifo's attempt flag, bit 0 being the transmit queue.
// - The upper halves of send request and the four pending vectors read 0.
`timescale 1ns/10ps
`default_nettype none

module cfia_top
	import cfia_pkg::*;
#(
	parameter int TIMEBASE_WIDTH = 32
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [5:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [5:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire cfia_fifo_flags_t    fifo_flags,
	input  wire cfia_events_t        events,
	input  wire logic                timebase_enable,
	output logic                     irq
);

	// ------------------------------------------------------------
	// free-running timebase, wrap detection
	// ------------------------------------------------------------
	logic [TIMEBASE_WIDTH-1:0] free_running_timebase;
	wire                       timebase_wrap = timebase_enable && (&free_running_timebase);
	// held at zero while stopped, so a restart always waits a full span before the first wrap
	wire  [TIMEBASE_WIDTH-1:0] next_timebase = free_running_timebase + 1'b1;

	always_ff @(posedge aclk) begin
		if (!aresetn || !timebase_enable) begin
			free_running_timebase <= '0;
		end else begin
			free_running_timebase <= next_timebase;
		end
	end

	// ------------------------------------------------------------
	// per-fifo pending summaries
	// ------------------------------------------------------------
	logic [7:0] rx_fifo_pending;
	logic [7:0] rx_fifo_overflow_pending;
	logic [7:0] tx_fifo_pending;
	logic [7:0] tx_fifo_attempt_pending;

	// one slice per fifo, registered so readback and summary flags agree in the same cycle
	for (genvar f = 0; f < CFIA_FIFO_COUNT; f++) begin : g_fifo
		// rx slot 0 does not exist; tx slot 0 is the transmit queue
		wire rx_live  = fifo_flags.rx_fifo[f] && CFIA_RX_FIFO_MASK[f];
		wire ovf_live = fifo_flags.rx_ovf[f] && CFIA_RX_FIFO_MASK[f];

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				rx_fifo_pending[f]          <= 1'b0;
				rx_fifo_overflow_pending[f] <= 1'b0;
			end else begin
				rx_fifo_pending[f]          <= rx_live;
				rx_fifo_overflow_pending[f] <= ovf_live;
			end
		end

		// flags arrive already gated by the per-fifo enables
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				tx_fifo_pending[f]         <= 1'b0;
				tx_fifo_attempt_pending[f] <= 1'b0;
			end else begin
				tx_fifo_pending[f]         <= fifo_flags.tx_fifo[f];
				tx_fifo_attempt_pending[f] <= fifo_flags.tx_att[f];
			end
		end
	end

	// ------------------------------------------------------------
	// enable register and event flags
	// ------------------------------------------------------------
	logic [15:0] interrupt_enable_mask;
	logic [15:0] sticky_flags;
	logic [15:0] hw_set;
	logic [15:0] sw_clear;
	logic [15:0] status_flags;
	logic [15:0] interrupt_event_flags;

	// ------------------------------------------------------------
	// event sources
	// ------------------------------------------------------------
	// pulses from the protocol side; the wrap comes from the local timebase
	always_comb begin
		hw_set = 16'h0000;
		hw_set[CFIA_BIT_BAD_MSG] = events.bad_message;
		hw_set[CFIA_BIT_WAKEUP]  = events.wakeup;
		hw_set[CFIA_BIT_BUS_ERR] = events.bus_error;
		hw_set[CFIA_BIT_SYS_ERR] = events.system_error;
		hw_set[CFIA_BIT_MODE]    = events.mode_change;
		hw_set[CFIA_BIT_TBWRAP]  = timebase_wrap;
	end

	// ------------------------------------------------------------
	// read-only summaries
	// ------------------------------------------------------------
	// cleared only below in the fifos themselves
	always_comb begin
		status_flags = 16'h0000;
		status_flags[CFIA_BIT_RX_OVF] = |rx_fifo_overflow_pending;
		status_flags[CFIA_BIT_TX_ATT] = |tx_fifo_attempt_pending;
		status_flags[CFIA_BIT_TEF]    = events.tx_event_fifo;
		status_flags[CFIA_BIT_RX_OBJ] = |rx_fifo_pending;
		status_flags[CFIA_BIT_TX_OBJ] = |tx_fifo_pending;
	end

	// ------------------------------------------------------------
	// flag register view
	// ------------------------------------------------------------
	assign interrupt_event_flags = (sticky_flags & CFIA_STICKY_MASK) | status_flags;

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	logic        aw_held;
	logic        w_held;
	logic [5:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	wire  [15:0] lane_mask;
	wire         aw_take   = s_axi_awvalid && s_axi_awready;
	wire         w_take    = s_axi_wvalid && s_axi_wready;
	wire         wr_fire   = aw_held && w_held && !s_axi_bvalid;
	wire  [15:0] wr_lo     = lane_mask & w_data[15:0];
	wire         wr_enable = wr_fire && (aw_addr == CFIA_OFS_ENABLE);
	wire         wr_flags  = wr_fire && (aw_addr == CFIA_OFS_FLAGS);
	// an unknown address is answered with an error but changes nothing
	wire         wr_known  = (aw_addr[1:0] == 2'b00) && (aw_addr <= CFIA_OFS_SEND_REQ_HI);

	// only the two low byte lanes carry register bits
	for (genvar l = 0; l < 2; l++) begin : g_lane
		assign lane_mask[8*l +: 8] = {8{w_strb[l]}};
	end

	// ------------------------------------------------------------
	// flag clear
	// ------------------------------------------------------------
	// writing 1 to a sticky flag clears it, a 0 leaves it alone; a set in the same cycle wins
	assign sw_clear = wr_flags ? (lane_mask & w_data[15:0] & CFIA_STICKY_MASK) : 16'h0000;

	// ------------------------------------------------------------
	// write address and data capture
	// ------------------------------------------------------------
	// each half is kept until both are present, so the master may offer them in any order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 6'h00;
		end else if (aw_take) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (w_take) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// write handshake readies and response
	// ------------------------------------------------------------
	// a ready stays low from its handshake until the response is accepted, so a held valid is never taken twice
	wire         next_awready = !aw_held && !aw_take && !s_axi_bvalid;
	wire         next_wready  = !w_held && !w_take && !s_axi_bvalid;
	wire         next_bvalid  = wr_fire || (s_axi_bvalid && !s_axi_bready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
		end else begin
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bresp <= CFIA_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bresp <= wr_known ? CFIA_RESP_OKAY : CFIA_RESP_SLVERR;
		end
	end

	// ------------------------------------------------------------
	// enable register
	// ------------------------------------------------------------
	wire  [15:0] next_enable = ((interrupt_enable_mask & ~lane_mask) | wr_lo) & CFIA_IMPL_MASK;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_enable_mask <= CFIA_RESET_VAL;
		end else if (wr_enable) begin
			interrupt_enable_mask <= next_enable;
		end
	end

	// ------------------------------------------------------------
	// sticky event flags
	// ------------------------------------------------------------
	// a hardware set lands even when software clears in the same cycle
	wire  [15:0] next_sticky = ((sticky_flags & ~sw_clear) | hw_set) & CFIA_STICKY_MASK;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sticky_flags <= CFIA_RESET_VAL;
		end else begin
			sticky_flags <= next_sticky;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read decode
	// ------------------------------------------------------------
	// summaries and upper halves have no write path at all
	wire         rd_sel_enable  = (s_axi_araddr == CFIA_OFS_ENABLE);
	wire         rd_sel_flags   = (s_axi_araddr == CFIA_OFS_FLAGS);
	wire         rd_sel_rx_lo   = (s_axi_araddr == CFIA_OFS_RX_PEND_LO);
	wire         rd_sel_ovf_lo  = (s_axi_araddr == CFIA_OFS_RX_OVF_LO);
	wire         rd_sel_tx_lo   = (s_axi_araddr == CFIA_OFS_TX_PEND_LO);
	wire         rd_sel_att_lo  = (s_axi_araddr == CFIA_OFS_TX_ATT_LO);
	wire         rd_sel_rx_hi   = (s_axi_araddr == CFIA_OFS_RX_PEND_HI);
	wire         rd_sel_ovf_hi  = (s_axi_araddr == CFIA_OFS_RX_OVF_HI);
	wire         rd_sel_tx_hi   = (s_axi_araddr == CFIA_OFS_TX_PEND_HI);
	wire         rd_sel_att_hi  = (s_axi_araddr == CFIA_OFS_TX_ATT_HI);
	wire         rd_sel_send_hi = (s_axi_araddr == CFIA_OFS_SEND_REQ_HI);
	// upper halves decode but contribute nothing to the data
	wire         rd_sel_zero    = rd_sel_rx_hi || rd_sel_ovf_hi || rd_sel_tx_hi
	                            || rd_sel_att_hi || rd_sel_send_hi;
	wire         rd_sel_low     = rd_sel_rx_lo || rd_sel_ovf_lo || rd_sel_tx_lo || rd_sel_att_lo;
	wire         rd_ok          = rd_sel_enable || rd_sel_flags || rd_sel_low || rd_sel_zero;
	wire  [15:0] rd_word        = ({16{rd_sel_enable}} & interrupt_enable_mask)
	                            | ({16{rd_sel_flags}}  & interrupt_event_flags)
	                            | ({16{rd_sel_rx_lo}}  & {8'h00, rx_fifo_pending})
	                            | ({16{rd_sel_ovf_lo}} & {8'h00, rx_fifo_overflow_pending})
	                            | ({16{rd_sel_tx_lo}}  & {8'h00, tx_fifo_pending})
	                            | ({16{rd_sel_att_lo}} & {8'h00, tx_fifo_attempt_pending});

	// ------------------------------------------------------------
	// read handshake
	// ------------------------------------------------------------
	wire         ar_take      = s_axi_arvalid && s_axi_arready;
	wire         next_arready = !s_axi_rvalid && !ar_take;
	wire         next_rvalid  = ar_take || (s_axi_rvalid && !s_axi_rready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
		end else begin
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
		end
	end

	// ------------------------------------------------------------
	// read data capture
	// ------------------------------------------------------------
	// data is captured at the address handshake and held until the master takes it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= CFIA_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rdata <= {16'h0000, rd_word};
			s_axi_rresp <= rd_ok ? CFIA_RESP_OKAY : CFIA_RESP_SLVERR;
		end
	end

	// ------------------------------------------------------------
	// interrupt output
	// ------------------------------------------------------------
	// registered so the pin never glitches while flags and enables change together
	wire  [15:0] irq_sources = interrupt_event_flags & interrupt_enable_mask;
	wire         next_irq    = |irq_sources;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

endmodule

`default_nettype wire

// ===== test/cfia_top_asserts.sv
// port checker for the interrupt aggregation block
`timescale 1ns/10ps
`default_nettype none
module cfia_top_asserts
	import cfia_pkg::*;
(
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic [5:0]       s_axi_araddr,
	input wire logic             s_axi_arvalid,
	input wire logic             s_axi_arready,
	input wire logic [31:0]      s_axi_rdata,
	input wire logic             s_axi_rvalid,
	input wire cfia_fifo_flags_t fifo_flags,
	input wire logic             irq
);
	logic [5:0] ra;
	logic [2:0] stab;
	wire        ok = s_axi_rvalid && stab > 3'h3;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	always_ff @(posedge aclk) begin
		if (!aresetn) ra <= 6'h00;
		else if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
	end
	// judge pending data only once inputs have passed the register stage
	always_ff @(posedge aclk) begin
		if (!aresetn || $changed(fifo_flags)) stab <= 3'h0;
		else if (stab != 3'h7) stab <= stab + 3'h1;
	end
	// ----
	// assertions
	// ----
	AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper half set");
	AST_HIGH_ZERO: assert property (s_axi_rvalid && ra inside {6'h08, 6'h10, 6'h18, 6'h20, 6'h28}
		|-> s_axi_rdata == 32'h0000_0000) else $error("high register set");
	AST_LOW_BYTE: assert property (s_axi_rvalid && ra inside {6'h0c, 6'h14, 6'h1c, 6'h24}
		|-> s_axi_rdata[15:8] == 8'h00) else $error("pending byte 1 set");
	AST_ENABLE_GAP: assert property (s_axi_rvalid && ra == 6'h00 |-> s_axi_rdata[9:5] == 5'h00)
		else $error("enable gap set");
	AST_RX_PEND: assert property (ok && ra == 6'h0c |-> s_axi_rdata[7:0] == {fifo_flags.rx_fifo[7:1], 1'b0})
		else $error("rx pending wrong");
	AST_TX_PEND: assert property (ok && ra == 6'h1c |-> s_axi_rdata[7:0] == fifo_flags.tx_fifo)
		else $error("tx pending wrong");
	AST_SUMMARY: assert property (ok && ra == 6'h04 |-> s_axi_rdata[11:10] ==
		{|fifo_flags.rx_ovf[7:1], |fifo_flags.tx_att} && s_axi_rdata[1:0] ==
		{|fifo_flags.rx_fifo[7:1], |fifo_flags.tx_fifo}) else $error("summary wrong");
	AST_IRQ_RESET: assert property ($rose(aresetn) |-> !irq ##1 !irq)
		else $error("irq after reset");
endmodule
bind cfia_top cfia_top_asserts chk_u (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .fifo_flags, .irq);
`default_nettype wire

// ===== test/cfia_host_model.sv
// host cpu model counting interrupt requests
`timescale 1ns/10ps
`default_nettype none
module cfia_host_model (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic irq,
	output var int    irq_edges
);
	logic irq_q;
	// a level request; counting entries exposes a stuck or missing one
	always_ff @(posedge aclk) begin
		irq_q <= irq;
		if (!aresetn) irq_edges <= 0;
		else if (irq && !irq_q) irq_edges <= irq_edges + 1;
	end
endmodule
`default_nettype wire

// ===== test/cfia_bench.sv
// self-checking bench for the interrupt aggregation block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; $display("BAD %s %h %h", n, e, g); end end
module cfia_bench
	import cfia_pkg::*;
;
	logic             aclk, aresetn, timebase_enable, irq, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic             s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic             s_axi_rvalid;
	logic [5:0]       s_axi_awaddr, s_axi_araddr;
	logic [31:0]      s_axi_wdata, s_axi_rdata, rd_val;
	logic [3:0]       s_axi_wstrb;
	logic [1:0]       s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0]      en, st;
	cfia_fifo_flags_t fifo_flags;
	cfia_events_t     events;
	int               failures, check_count, cycles, irq_edges, e0;
	int               seed = 32'h2ffe_6568;
	cfia_top #(.TIMEBASE_WIDTH(4)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .fifo_flags, .events, .timebase_enable, .irq);
	cfia_host_model host_u (.aclk, .aresetn, .irq, .irq_edges);
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			failures++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// ----
	// bus cycles and expectations
	// ----
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic chk_reg(input logic [5:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rd_val = s_axi_rdata;
		s_axi_rready <= 1'b0;
		`CHK("rdata", exp_reg(a), rd_val)
		`CHK("rresp", (a <= 6'h28) ? CFIA_RESP_OKAY : CFIA_RESP_SLVERR, s_axi_rresp)
	endtask
	function automatic logic [31:0] exp_reg(input logic [5:0] a);
		case (a)
			6'h00: return {16'h0000, en & 16'hfc1f};
			6'h04: return {16'h0000, st[15:12], |fifo_flags.rx_ovf[7:1], |fifo_flags.tx_att, 5'h00,
				events.tx_event_fifo, st[3:2], |fifo_flags.rx_fifo[7:1], |fifo_flags.tx_fifo};
			6'h0c: return {24'h00_0000, fifo_flags.rx_fifo[7:1], 1'b0};
			6'h14: return {24'h00_0000, fifo_flags.rx_ovf[7:1], 1'b0};
			6'h1c: return {24'h00_0000, fifo_flags.tx_fifo};
			6'h24: return {24'h00_0000, fifo_flags.tx_att};
			default: return 32'h0000_0000;
		endcase
	endfunction
	initial begin
		{aresetn, timebase_enable, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, fifo_flags, events, en, st} = '0;
		s_axi_wstrb = 4'hf;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		wr(6'h3c, 32'hffff_ffff);
		`CHK("bresp", CFIA_RESP_SLVERR, rsp)
		for (int a = 0; a < 64; a += 4) chk_reg(6'(a));
		wr(6'h00, 32'hffff_ffff);
		en = 16'hffff;
		chk_reg(6'h00);
		for (int i = 0; i < 24; i++) begin
			fifo_flags <= (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0101_0101 : 32'($random(seed));
			events.tx_event_fifo <= i[1];
			repeat (4) @(posedge aclk);
			wr(6'h04, 32'h0000_ffff);
			wr(6'h0c, 32'h0000_0000);
			for (int a = 4; a < 40; a += 4) chk_reg(6'(a));
			rd_val = exp_reg(6'h04);
			`CHK("irq", |(rd_val[15:0] & en), irq)
		end
		fifo_flags <= '0;
		events <= '0;
		repeat (4) @(posedge aclk);
		for (int i = 0; i < 5; i++) begin
			events <= 6'(6'h20 >> i);
			@(posedge aclk);
			events <= 6'h00;
			st = (i < 4) ? 16'(16'h8000 >> i) : 16'h0008;
			repeat (2) @(posedge aclk);
			`CHK("irq", 1'b1, irq)
			wr(6'h04, 32'h0000_0000);
			chk_reg(6'h04);
			wr(6'h04, {16'h0000, st});
			st = 16'h0000;
			chk_reg(6'h04);
		end
		e0 = irq_edges;
		wr(6'h00, 32'h0000_0004);
		en = 16'h0004;
		timebase_enable <= 1'b1;
		repeat (40) @(posedge aclk);
		timebase_enable <= 1'b0;
		st = 16'h0004;
		chk_reg(6'h04);
		`CHK("irq", 1'b1, irq)
		wr(6'h00, 32'h0000_0000);
		en = 16'h0000;
		repeat (2) @(posedge aclk);
		`CHK("irq", 1'b0, irq)
		`CHK("irq edges", e0 + 1, irq_edges)
		wr(6'h04, 32'h0000_0004);
		st = 16'h0000;
		chk_reg(6'h04);
		end_of_test();
	end
endmodule
`default_nettype wire
